// ===== sim/pcic_idle_code_chk.sv
`include "pcic_params.svh"

module pcic_idle_code_chk #(
  parameter int T1_CH = `PCIC_T1_CH
) (
  input wire logic                 i_sys_clk,
  input wire logic                 i_sys_rst,
  input wire logic                 i_rd_stb,
  input wire pcic_pkg::pcic_byte_t o_rd_data,
  input wire logic                 i_tx_valid,
  input wire pcic_pkg::pcic_chan_t i_tx_chan,
  input wire pcic_pkg::pcic_byte_t i_tx_data,
  input wire logic                 o_tx_valid,
  input wire pcic_pkg::pcic_byte_t o_tx_data,
  input wire logic                 o_tx_subst,
  input wire logic                 i_tx_bit_en,
  input wire logic                 o_tx_line_bit,
  input wire logic                 i_rx_valid,
  input wire pcic_pkg::pcic_byte_t i_rx_data,
  input wire logic                 o_rx_valid,
  input wire pcic_pkg::pcic_byte_t o_rx_data,
  input wire logic                 o_rx_subst,
  input wire logic                 o_t1_mode
);
  import pcic_pkg::*;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);

  a_rd_quiet: assert property (!i_rd_stb |=> o_rd_data == 8'h00)
    else $error("read data seen without a read strobe");
  a_tx_timing: assert property (o_tx_valid == $past(i_tx_valid))
    else $error("transmit byte not one cycle after input");
  a_rx_timing: assert property (o_rx_valid == $past(i_rx_valid))
    else $error("receive byte not one cycle after input");
  a_tx_pass: assert property ($past(i_tx_valid) && !o_tx_subst |-> o_tx_data == $past(i_tx_data))
    else $error("unreplaced transmit byte altered");
  a_rx_pass: assert property ($past(i_rx_valid) && !o_rx_subst |-> o_rx_data == $past(i_rx_data))
    else $error("unreplaced receive byte altered");
  a_t1_ignore: assert property (o_t1_mode && i_tx_valid && i_tx_chan >= T1_CH |=> !o_tx_subst)
    else $error("upper channel replaced in T1 mode");
  a_tx_hold: assert property (!o_tx_valid |-> $stable(o_tx_data))
    else $error("transmit data moved without valid");
  a_msb_first: assert property (o_tx_valid ##1 (i_tx_bit_en && !o_tx_valid) |=>
    o_tx_line_bit == $past(o_tx_data[7])) else $error("first line bit is not C7");
  a_lsb_last: assert property (o_tx_valid ##1 (i_tx_bit_en && !o_tx_valid)[*8] |=>
    o_tx_line_bit == $past(o_tx_data[0])) else $error("eighth line bit is not C0");

  c_tx_subst: cover property (o_tx_valid && o_tx_subst);
  c_rx_subst: cover property (o_rx_valid && o_rx_subst);
  c_read: cover property (i_rd_stb ##1 o_rd_data != 8'h00);
endmodule

bind pcic_idle_code pcic_idle_code_chk #(.T1_CH(T1_CH)) u_chk (
  .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_rd_stb(i_rd_stb), .o_rd_data(o_rd_data),
  .i_tx_valid(i_tx_valid), .i_tx_chan(i_tx_chan), .i_tx_data(i_tx_data),
  .o_tx_valid(o_tx_valid), .o_tx_data(o_tx_data), .o_tx_subst(o_tx_subst),
  .i_tx_bit_en(i_tx_bit_en), .o_tx_line_bit(o_tx_line_bit), .i_rx_valid(i_rx_valid),
  .i_rx_data(i_rx_data), .o_rx_valid(o_rx_valid), .o_rx_data(o_rx_data),
  .o_rx_subst(o_rx_subst), .o_t1_mode(o_t1_mode));

// ===== sim/per_channel_idle_code_array_test.sv
module per_channel_idle_code_array_test;
  timeunit 1ns;
  timeprecision 1ps;
  import pcic_pkg::*;
  logic       i_sys_clk = 1'b0;
  logic       i_sys_rst = 1'b1;
  pcic_addr_t i_addr = 8'h00;
  pcic_byte_t i_wr_data = 8'h00;
  logic       i_wr_stb = 1'b0;
  logic       i_rd_stb = 1'b0;
  logic       i_tx_valid = 1'b0;
  pcic_chan_t i_tx_chan = 5'h00;
  pcic_byte_t i_tx_data = 8'h00;
  logic       i_tx_bit_en = 1'b0;
  logic       i_rx_valid = 1'b0;
  pcic_chan_t i_rx_chan = 5'h00;
  pcic_byte_t i_rx_data = 8'h00;
  pcic_byte_t o_rd_data, o_tx_data, o_rx_data;
  logic       o_tx_valid, o_tx_subst, o_tx_line_bit, o_rx_valid, o_rx_subst, o_t1_mode;
  int         cmp_count = 0;
  int         bad_count = 0;
  logic [15:0] seed = 16'h0003;
  logic [7:0] arr [64];
  logic [7:0] ptr = 8'h00;
  logic [7:0] last_tx, v, w;
  logic [31:0] ten = 32'h0, ren = 32'h0;
  logic       t1m = 1'b0;

  pcic_idle_code uut (
    .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wr_data(i_wr_data),
    .i_wr_stb(i_wr_stb), .i_rd_stb(i_rd_stb), .o_rd_data(o_rd_data),
    .i_tx_valid(i_tx_valid), .i_tx_chan(i_tx_chan), .i_tx_data(i_tx_data),
    .o_tx_valid(o_tx_valid), .o_tx_data(o_tx_data), .o_tx_subst(o_tx_subst),
    .i_tx_bit_en(i_tx_bit_en), .o_tx_line_bit(o_tx_line_bit), .i_rx_valid(i_rx_valid),
    .i_rx_chan(i_rx_chan), .i_rx_data(i_rx_data), .o_rx_valid(o_rx_valid),
    .o_rx_data(o_rx_data), .o_rx_subst(o_rx_subst), .o_t1_mode(o_t1_mode));

  always #2 i_sys_clk = ~i_sys_clk;

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic rnd(output logic [7:0] r);
    seed = lfsr(seed);
    r = seed[7:0];
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Register write; the expected array, pointer and enables follow along.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    if (a == 8'h7e) ptr = d;
    if (a == 8'h70) t1m = d[0];
    if (a[7:3] == 5'h10) begin
      if (a[2]) ren[a[1:0]*8 +: 8] = d;
      else ten[a[1:0]*8 +: 8] = d;
    end
    if (a == 8'h7f) begin
      for (int i = 0; i < 64; i++)
        if ((ptr[6] && i < 32) || (ptr[7] && i >= 32) || (ptr[7:6] == 2'b00 && i == ptr[5:0]))
          arr[i] = d;
      ptr[5:0] = ptr[5:0] + 6'h01;
    end
    @(posedge i_sys_clk);
    i_addr <= a;
    i_wr_data <= d;
    i_wr_stb <= 1'b1;
    @(posedge i_sys_clk);
    i_wr_stb <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    logic [7:0] e;
    e = 8'h00;
    if (a == 8'h7e) e = ptr;
    if (a == 8'h70) e = {7'h00, t1m};
    if (a[7:3] == 5'h10) e = a[2] ? ren[a[1:0]*8 +: 8] : ten[a[1:0]*8 +: 8];
    if (a == 8'h7f) begin
      e = arr[ptr[5:0]];
      ptr[5:0] = ptr[5:0] + 6'h01;
    end
    @(posedge i_sys_clk);
    i_addr <= a;
    i_rd_stb <= 1'b1;
    @(posedge i_sys_clk);
    i_rd_stb <= 1'b0;
    #1 chk(o_rd_data, e);
  endtask

  task automatic strm(input logic [4:0] c, input logic [7:0] dt, input logic [7:0] dr);
    logic st, sr;
    st = ten[c] && !(t1m && c >= 5'd24);
    sr = ren[c] && !(t1m && c >= 5'd24);
    last_tx = st ? arr[{1'b0, c}] : dt;
    @(posedge i_sys_clk);
    i_tx_valid <= 1'b1;
    i_tx_chan <= c;
    i_tx_data <= dt;
    i_rx_valid <= 1'b1;
    i_rx_chan <= c;
    i_rx_data <= dr;
    @(posedge i_sys_clk);
    i_tx_valid <= 1'b0;
    i_rx_valid <= 1'b0;
    #1 chk(o_tx_data, last_tx);
    chk({6'h00, o_tx_valid, o_tx_subst}, {6'h00, 1'b1, st});
    chk(o_rx_data, sr ? arr[{1'b1, c}] : dr);
    chk({6'h00, o_rx_valid, o_rx_subst}, {6'h00, 1'b1, sr});
  endtask

  task automatic ser();
    @(posedge i_sys_clk);
    i_tx_bit_en <= 1'b1;
    for (int b = 7; b >= 0; b--) begin
      @(posedge i_sys_clk);
      if (b == 0) i_tx_bit_en <= 1'b0;
      #1 chk({7'h00, o_tx_line_bit}, {7'h00, last_tx[b]});
    end
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    foreach (arr[i]) arr[i] = 8'h00;
    repeat (20) @(posedge i_sys_clk);
    i_sys_rst <= 1'b0;
    rd(8'h7e);
    for (int a = 8'h80; a < 8'h88; a++) rd(a[7:0]);
    rd(8'h70);
    rd(8'h90);
    rd(8'h7f);
    rd(8'h7e);
    $display("reset values done");
    wr(8'h7e, 8'h02);
    for (int i = 0; i < 4; i++) begin
      rnd(v);
      wr(8'h7f, v);
    end
    rd(8'h7e);
    wr(8'h7e, 8'h3e);
    for (int i = 0; i < 64; i++) begin
      rnd(v);
      wr(8'h7f, v);
    end
    wr(8'h90, 8'h5a);
    rd(8'h7e);
    for (int i = 0; i < 64; i++) rd(8'h7f);
    $display("pointer tests done");
    for (int g = 1; g < 4; g++) begin
      rnd(v);
      wr(8'h7e, {g[1:0], 6'h05});
      wr(8'h7f, v);
      rd(8'h7e);
      wr(8'h7e, 8'h00);
      for (int i = 0; i < 64; i++) rd(8'h7f);
    end
    $display("global load tests done");
    for (int m = 0; m < 2; m++) begin
      wr(8'h70, m[7:0]);
      rd(8'h70);
      chk({7'h00, o_t1_mode}, {7'h00, t1m});
      for (int a = 8'h80; a < 8'h88; a++) begin
        rnd(v);
        if (m == 0 && (a == 8'h80 || a == 8'h82)) v[0] = 1'b0;
        wr(a[7:0], v);
      end
      for (int i = 0; i < 64; i++) begin
        rnd(v);
        rnd(w);
        strm(seed[12:8], v, w);
      end
      ser();
    end
    $display("stream tests done");
    test_done();
  end
endmodule

// ===== src/pcic_chan_subst.sv
`include "pcic_params.svh"

module pcic_chan_subst #(
  parameter int NUM_CH = `PCIC_NUM_CH,
  parameter int T1_CH  = `PCIC_T1_CH
) (
  // Clock and reset.
  input  wire logic              i_sys_clk,
  input  wire logic              i_sys_rst,
  // Control.
  input  wire logic              i_t1_mode,
  input  wire logic [NUM_CH-1:0] i_en_mask,
  // Incoming channel byte.
  input  wire logic              i_valid,
  input  wire pcic_pkg::pcic_chan_t i_chan,
  input  wire pcic_pkg::pcic_byte_t i_data,
  input  wire pcic_pkg::pcic_byte_t i_code,
  // Outgoing channel byte.
  output logic                   o_valid,
  output pcic_pkg::pcic_byte_t   o_data,
  output logic                   o_subst
);
  import pcic_pkg::*;

  logic       in_t1_range;
  logic       use_code;
  pcic_byte_t data_next;
  logic       valid_reg;
  pcic_byte_t data_reg;
  logic       subst_reg;

  // Channels beyond the T1 frame are never substituted in T1 mode.
  assign in_t1_range = (32'(i_chan) < T1_CH);
  assign use_code    = i_en_mask[i_chan] && (!i_t1_mode || in_t1_range);
  assign data_next   = use_code ? i_code : i_data;

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      valid_reg <= 1'b0;
      data_reg  <= 8'h00;
      subst_reg <= 1'b0;
    end else begin
      valid_reg <= i_valid;
      if (i_valid) begin
        data_reg  <= data_next;
        subst_reg <= use_code;
      end
    end
  end

  assign o_valid = valid_reg;
  assign o_data  = data_reg;
  assign o_subst = subst_reg;
endmodule

// ===== src/pcic_idle_code.sv

`include "pcic_params.svh"

module pcic_idle_code #(
  parameter int NUM_CH  = `PCIC_NUM_CH,
  parameter int T1_CH   = `PCIC_T1_CH
) (
  // Clock and reset.
  input  wire logic                 i_sys_clk,
  input  wire logic                 i_sys_rst,
  // Register port.
  input  wire pcic_pkg::pcic_addr_t i_addr,
  input  wire pcic_pkg::pcic_byte_t i_wr_data,
  input  wire logic                 i_wr_stb,
  input  wire logic                 i_rd_stb,
  output pcic_pkg::pcic_byte_t      o_rd_data,
  // Transmit stream from the backplane.
  input  wire logic                 i_tx_valid,
  input  wire pcic_pkg::pcic_chan_t i_tx_chan,
  input  wire pcic_pkg::pcic_byte_t i_tx_data,
  // Transmit stream toward the line.
  output logic                      o_tx_valid,
  output pcic_pkg::pcic_byte_t      o_tx_data,
  output logic                      o_tx_subst,
  // Transmit line bit, one bit per bit enable.
  input  wire logic                 i_tx_bit_en,
  output logic                      o_tx_line_bit,
  // Receive stream from the line.
  input  wire logic                 i_rx_valid,
  input  wire pcic_pkg::pcic_chan_t i_rx_chan,
  input  wire pcic_pkg::pcic_byte_t i_rx_data,
  // Receive stream toward the backplane.
  output logic                      o_rx_valid,
  output pcic_pkg::pcic_byte_t      o_rx_data,
  output logic                      o_rx_subst,
  // Mode status.
  output logic                      o_t1_mode
);
  import pcic_pkg::*;

  // Register state.
  pcic_byte_t        pointer_reg;
  pcic_byte_t        pointer_next;
  logic              t1_mode_reg;
  logic [NUM_CH-1:0] tx_en_reg;
  logic [NUM_CH-1:0] rx_en_reg;
  pcic_byte_t        rd_data_reg;
  // Lower half holds transmit codes, upper half receive codes.
  pcic_byte_t        code_mem [`PCIC_NUM_ENTRIES];

  // Line serializer state.
  pcic_byte_t        tx_shift_reg;
  logic              tx_line_bit_reg;

  // Address decode: one named select per register.
  logic       sel_mode;
  logic       sel_pointer;
  logic       sel_code;
  logic       sel_tx_en0;
  logic       sel_tx_en1;
  logic       sel_tx_en2;
  logic       sel_tx_en3;
  logic       sel_rx_en0;
  logic       sel_rx_en1;
  logic       sel_rx_en2;
  logic       sel_rx_en3;
  logic [3:0] sel_tx_en;
  logic [3:0] sel_rx_en;
  logic       sel_any;

  assign sel_mode    = (i_addr == `PCIC_ADDR_MODE);
  assign sel_pointer = (i_addr == `PCIC_ADDR_POINTER);
  assign sel_code    = (i_addr == `PCIC_ADDR_CODE);
  assign sel_tx_en0  = (i_addr == `PCIC_ADDR_TX_EN0);
  assign sel_tx_en1  = (i_addr == `PCIC_ADDR_TX_EN1);
  assign sel_tx_en2  = (i_addr == `PCIC_ADDR_TX_EN2);
  assign sel_tx_en3  = (i_addr == `PCIC_ADDR_TX_EN3);
  assign sel_rx_en0  = (i_addr == `PCIC_ADDR_RX_EN0);
  assign sel_rx_en1  = (i_addr == `PCIC_ADDR_RX_EN1);
  assign sel_rx_en2  = (i_addr == `PCIC_ADDR_RX_EN2);
  assign sel_rx_en3  = (i_addr == `PCIC_ADDR_RX_EN3);
  assign sel_tx_en   = {sel_tx_en3, sel_tx_en2, sel_tx_en1, sel_tx_en0};
  assign sel_rx_en   = {sel_rx_en3, sel_rx_en2, sel_rx_en1, sel_rx_en0};
  // Unmapped addresses match no select.
  assign sel_any     = sel_mode | sel_pointer | sel_code | (|sel_tx_en) | (|sel_rx_en);

  // Write strobes for the enable banks and the mode register.
  // Writes to unmapped addresses match no strobe and are dropped.
  logic [3:0] tx_en_wr;
  logic [3:0] rx_en_wr;
  logic       mode_wr;
  logic       rd_hit;

  assign tx_en_wr = sel_tx_en & {4{i_wr_stb}};
  assign rx_en_wr = sel_rx_en & {4{i_wr_stb}};
  assign mode_wr  = sel_mode & i_wr_stb;
  // Unmapped reads return zero, the same as the idle value of the read port.
  assign rd_hit   = i_rd_stb & sel_any;

  // Pointer fields.
  // Bits 7:6 only widen data writes; reads ignore them.
  pcic_index_t ptr_index;
  pcic_index_t ptr_index_inc;
  logic        global_tx;
  logic        global_rx;

  assign ptr_index     = pointer_reg[`PCIC_PTR_MSB:0];
  assign global_tx     = pointer_reg[`PCIC_GLOBAL_TX_BIT];
  assign global_rx     = pointer_reg[`PCIC_GLOBAL_RX_BIT];
  // The index wraps from the last receive entry back to the first transmit entry.
  assign ptr_index_inc = ptr_index + `PCIC_PTR_STEP;

  // Data access strobes.
  // Only the code data register steps the pointer; other registers leave it alone.
  logic code_wr;
  logic code_rd;
  logic ptr_wr;

  assign code_wr = i_wr_stb & sel_code;
  assign code_rd = i_rd_stb & sel_code;
  assign ptr_wr  = i_wr_stb & sel_pointer;

  // Software writes to the pointer take the whole byte; data accesses step the index
  // and leave the global bits as they were.
  // A data access with a global bit set steps the index as well.
  assign pointer_next = ptr_wr ? i_wr_data :
                        (code_wr | code_rd) ? {pointer_reg[`PCIC_GLOBAL_RX_BIT:
                                                           `PCIC_GLOBAL_TX_BIT],
                                               ptr_index_inc} :
                        pointer_reg;

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      pointer_reg <= `PCIC_RST_POINTER;
    end else begin
      pointer_reg <= pointer_next;
    end
  end

  // Per-entry write enables for the code array.
  // Each half compares the full six-bit index, so a single write never lands in the
  // other half; with both global bits set one write loads all sixty-four entries.
  logic [`PCIC_NUM_ENTRIES-1:0] entry_wr;
  logic                         any_global;

  // Any global bit turns off the single-entry write.
  assign any_global = global_tx | global_rx;

  genvar gi;
  generate
    for (gi = 0; gi < `PCIC_NUM_ENTRIES; gi++) begin : g_entry
      if (gi < `PCIC_RX_BASE) begin : g_tx
        // Transmit half: pointed entry or global transmit load.
        assign entry_wr[gi] = code_wr &
                              ((!any_global && ptr_index == 6'(gi)) ||
                               global_tx);
      end else begin : g_rx
        // Receive half: pointed entry or global receive load.
        assign entry_wr[gi] = code_wr &
                              ((!any_global && ptr_index == 6'(gi)) ||
                               global_rx);
      end
    end
  endgenerate

  // The array is reached only through the data register.
  // Reset clears every entry so an enabled channel never carries an unknown byte.
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      for (int i = 0; i < `PCIC_NUM_ENTRIES; i++) begin
        code_mem[i] <= `PCIC_RST_CODE;
      end
    end else begin
      for (int i = 0; i < `PCIC_NUM_ENTRIES; i++) begin
        if (entry_wr[i]) begin
          code_mem[i] <= i_wr_data;
        end
      end
    end
  end

  // Enable and mode registers. Enable bits for channels 24 to 31 are kept in T1 mode
  // as well; only the substitution logic ignores them there.
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      tx_en_reg   <= `PCIC_RST_ENABLE;
      rx_en_reg   <= `PCIC_RST_ENABLE;
      t1_mode_reg <= `PCIC_RST_MODE;
    end else begin
      for (int b = 0; b < 4; b++) begin
        if (tx_en_wr[b]) begin
          tx_en_reg[b*8 +: 8] <= i_wr_data;
        end
        if (rx_en_wr[b]) begin
          rx_en_reg[b*8 +: 8] <= i_wr_data;
        end
      end
      if (mode_wr) begin
        t1_mode_reg <= i_wr_data[`PCIC_MODE_T1_BIT];
      end
    end
  end

  // Read selection.
  // The enable banks share one lane select made from the two low address bits.
  // A code read with a global bit set still returns the pointed entry.
  // The mode register reads back its single bit with zeros above.
  pcic_byte_t tx_en_byte;
  pcic_byte_t rx_en_byte;
  pcic_byte_t code_byte;
  pcic_byte_t mode_byte;
  pcic_byte_t rd_mux;
  logic [1:0] en_sel;

  assign en_sel     = i_addr[1:0];
  assign tx_en_byte = tx_en_reg[en_sel*8 +: 8];
  assign rx_en_byte = rx_en_reg[en_sel*8 +: 8];
  assign code_byte  = code_mem[ptr_index];
  assign mode_byte  = {7'h00, t1_mode_reg};

  assign rd_mux = sel_mode        ? mode_byte   :
                  sel_pointer     ? pointer_reg :
                  sel_code        ? code_byte   :
                  (|sel_tx_en)    ? tx_en_byte  :
                  (|sel_rx_en)    ? rx_en_byte  :
                  8'h00;

  // Read data stand for the single cycle after the strobe; zero otherwise.
  // Holding zero between reads keeps the port quiet when several blocks share it.
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      rd_data_reg <= 8'h00;
    end else if (rd_hit) begin
      rd_data_reg <= rd_mux;
    end else begin
      rd_data_reg <= 8'h00;
    end
  end

  // Code lookup for the channel currently on each stream.
  // The code is read in the cycle the byte is taken, so a code rewritten while its
  // channel is enabled applies from the next byte of that channel on.
  pcic_index_t tx_code_index;
  pcic_index_t rx_code_index;
  pcic_byte_t  tx_code;
  pcic_byte_t  rx_code;

  assign tx_code_index = {1'b0, i_tx_chan};
  assign rx_code_index = {1'b1, i_rx_chan};
  assign tx_code       = code_mem[tx_code_index];
  assign rx_code       = code_mem[rx_code_index];

  // Transmit direction substitution.
  // Its registered outputs drive the top-level ports and the serializer directly.
  pcic_byte_t tx_out_data;
  logic       tx_out_valid;

  pcic_chan_subst #(
    .NUM_CH (NUM_CH),
    .T1_CH  (T1_CH)
  ) u_tx_subst (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .i_t1_mode (t1_mode_reg),
    .i_en_mask (tx_en_reg),
    .i_valid   (i_tx_valid),
    .i_chan    (i_tx_chan),
    .i_data    (i_tx_data),
    .i_code    (tx_code),
    .o_valid   (tx_out_valid),
    .o_data    (tx_out_data),
    .o_subst   (o_tx_subst)
  );

  // Receive direction substitution.
  // Receive codes sit in the upper half of the array; receive bytes leave whole.
  pcic_chan_subst #(
    .NUM_CH (NUM_CH),
    .T1_CH  (T1_CH)
  ) u_rx_subst (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .i_t1_mode (t1_mode_reg),
    .i_en_mask (rx_en_reg),
    .i_valid   (i_rx_valid),
    .i_chan    (i_rx_chan),
    .i_data    (i_rx_data),
    .i_code    (rx_code),
    .o_valid   (o_rx_valid),
    .o_data    (o_rx_data),
    .o_subst   (o_rx_subst)
  );

  // Line serializer: the most significant bit leaves first, so C0 is sent last.
  // A new byte reloads the shifter even if the previous one was not fully sent.
  // After its eighth bit the shifter runs on zeros, so the line idles low.
  pcic_byte_t tx_shift_next;
  logic       tx_line_bit_next;
  logic       tx_bit_step;

  assign tx_bit_step      = !tx_out_valid && i_tx_bit_en;
  assign tx_shift_next    = tx_out_valid ? tx_out_data :
                            tx_bit_step  ? {tx_shift_reg[6:0], 1'b0} :
                            tx_shift_reg;
  assign tx_line_bit_next = tx_bit_step ? tx_shift_reg[7] : tx_line_bit_reg;

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      tx_shift_reg    <= 8'h00;
      tx_line_bit_reg <= 1'b0;
    end else begin
      tx_shift_reg    <= tx_shift_next;
      tx_line_bit_reg <= tx_line_bit_next;
    end
  end

  assign o_rd_data     = rd_data_reg;
  assign o_tx_valid    = tx_out_valid;
  assign o_tx_data     = tx_out_data;
  assign o_tx_line_bit = tx_line_bit_reg;
  assign o_t1_mode     = t1_mode_reg;
endmodule

// ===== src/pcic_params.svh
`ifndef PCIC_PARAMS_SVH
`define PCIC_PARAMS_SVH

// Register addresses on the parallel register port.
`define PCIC_ADDR_MODE      8'h70
`define PCIC_ADDR_POINTER   8'h7e
`define PCIC_ADDR_CODE      8'h7f
`define PCIC_ADDR_TX_EN0    8'h80
`define PCIC_ADDR_TX_EN1    8'h81
`define PCIC_ADDR_TX_EN2    8'h82
`define PCIC_ADDR_TX_EN3    8'h83
`define PCIC_ADDR_RX_EN0    8'h84
`define PCIC_ADDR_RX_EN1    8'h85
`define PCIC_ADDR_RX_EN2    8'h86
`define PCIC_ADDR_RX_EN3    8'h87

// Reset values.
`define PCIC_RST_POINTER    8'h00
`define PCIC_RST_CODE       8'h00
`define PCIC_RST_ENABLE     32'h0000_0000
`define PCIC_RST_MODE       1'b0

// Field positions in the pointer register.
`define PCIC_PTR_MSB        5
`define PCIC_GLOBAL_TX_BIT  6
`define PCIC_GLOBAL_RX_BIT  7
`define PCIC_PTR_STEP       6'h01

// Field position in the mode register.
`define PCIC_MODE_T1_BIT    0

// Array layout.
`define PCIC_NUM_ENTRIES    64
`define PCIC_NUM_CH         32
`define PCIC_T1_CH          24
`define PCIC_RX_BASE        32

`endif

// ===== src/pcic_pkg.sv
package pcic_pkg;
  typedef logic [7:0] pcic_byte_t;
  typedef logic [7:0] pcic_addr_t;
  typedef logic [4:0] pcic_chan_t;
  typedef logic [5:0] pcic_index_t;
endpackage
